// >>> rtl/mlof_consts.svh
// constants of the multilane output framer: codes, field values, timing
// assumes nothing; included by the design modules and the testbench
`ifndef MLOF_CONSTS_SVH
`define MLOF_CONSTS_SVH

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define MLOF_LANES 4
`define MLOF_FRAME_BITS 66
`define MLOF_SYNC_DATA 2'h1
`define MLOF_SYNC_CTRL 2'h2
`define MLOF_HDR_MARK 7'h01

// ----------------------------------------------------------------
// register frame type codes
// ----------------------------------------------------------------
`define MLOF_ZZ_AUTO_AUTO 8'hb4
`define MLOF_ZZ_AUTO_REQ 8'h55
`define MLOF_ZZ_REQ_AUTO 8'h99
`define MLOF_ZZ_REQ_REQ 8'hd2
`define MLOF_ZZ_ERROR 8'hcc
// idle frame type code: arbitrary neutral value
`define MLOF_IDLE_CODE 8'h1e

// ----------------------------------------------------------------
// status codes
// ----------------------------------------------------------------
`define MLOF_ST_READY 4'h0
`define MLOF_ST_ERROR 4'h1
`define MLOF_ST_WARN 4'h2
`define MLOF_ST_BOTH 4'h3
`define MLOF_ST_TRIG_FULL 4'h5
`define MLOF_ST_NO_LOCK 4'h6

// ----------------------------------------------------------------
// queue, scrambler, timing
// ----------------------------------------------------------------
`define MLOF_RDQ_DEPTH 8
`define MLOF_SCR_SEED 58'h3ff_ffff_ffff_ffff
`define MLOF_LANE_RATE_MBPS 1280
`define MLOF_MCLK_PERIOD_NS 10

`endif

// >>> rtl/mlof_pkg.sv
// types of the multilane output framer
// assumes nothing; uses none of the constants of mlof_consts.svh
package mlof_pkg;

  // frame category sent on all active lanes in one frame period
  typedef enum logic [1:0] {
    MLOF_IDLE = 2'b00,
    MLOF_DATA = 2'b01,
    MLOF_REG = 2'b10
  } mlof_kind_t;

  // one read-back queue entry: extended address and captured value
  typedef struct packed {
    logic [9:0] eaddr;
    logic [15:0] value;
  } mlof_rdq_t;

endpackage

// >>> rtl/mlof_scrambler.sv
// self-synchronous 64b/66b scrambler for one lane's 64 payload bits
// assumes the caller keeps the sync header outside and pulses advance
// once per transmitted frame
`timescale 1ns/1ps
`default_nettype none
`include "mlof_consts.svh"

module mlof_scrambler (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic advance,
  input wire logic [63:0] payload,
  output logic [63:0] scrambled
);

  logic [57:0] state;
  logic [57:0] next_state;

  // ----------------------------------------------------------------
  // polynomial x^58 + x^39 + 1, bit 0 first
  // ----------------------------------------------------------------
  always_comb begin
    logic [57:0] s;
    s = state;
    scrambled = 64'h0;
    for (int k = 0; k < 64; k++) begin
      scrambled[k] = payload[k] ^ s[38] ^ s[57];
      s = {s[56:0], scrambled[k]};
    end
    next_state = s;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= `MLOF_SCR_SEED;
    end else if (advance) begin
      state <= next_state;
    end
  end

endmodule
`default_nettype wire

// >>> rtl/mlof_output_framer.sv
// multilane output framer: data, header and register frames on 1-4 lanes
// assumes same-clock config, record and read-back sources; only
// ext_clk_pin comes from outside the mclk domain
//
// Function
// - one to four lanes, count chosen by configuration
// - frame rate full, divided by 2, 4, 8, or from external clock
// - all active lanes send the same frame category each period
// - 66-bit frames, sync 01 for data, 10 for control or user
// - repeat programmable count of data slots then one register frame
// - idle fills empty data slots; register frames only in own slot
// - register frame: type, two address/value pairs, four status bits
// - extended address: 0 plus global address, or 1 plus pixel row
// - type code tells auto-filled or requested fields, or error
// - register frame is auto-filled even without read requests
// - each lane has its own two auto-fill selections
// - requested reads go to lane 0 only, ahead of auto-fill
// - one pending: first auto, second requested; two: both requested
// - status: ready, error, warning, both, trigger full, no lock
// - data frame holds two four-pixel groups, column index and row
// - event headers go out as data frames with sync 01
// - header: pattern 0000001, trigger id, tag, bunch crossing count
// - contents formatted before scrambling; receiver descrambles
// - hit record: 16-bit group address then four 4-bit charges
`timescale 1ns/1ps
`default_nettype none
`include "mlof_consts.svh"

module mlof_output_framer (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [1:0] active_lanes_sel,
  input wire logic [1:0] rate_div_sel,
  input wire logic ext_clk_sel,
  input wire logic ext_clk_pin,
  input wire logic [7:0] data_slots,
  input wire logic rec_valid,
  output logic rec_ready,
  input wire logic rec_is_header,
  input wire logic [15:0] rec_pixel_addr,
  input wire logic [15:0] rec_charge,
  input wire logic [4:0] rec_trigger_id,
  input wire logic [4:0] rec_trigger_tag,
  input wire logic [14:0] rec_bunch_crossing_count,
  input wire logic register_readback_request,
  input wire logic [8:0] readback_reg_addr,
  input wire logic [15:0] readback_value,
  input wire logic [8:0] pixel_row_addr,
  input wire logic [39:0] autofill_select_first,
  input wire logic [39:0] autofill_select_second,
  input wire logic [63:0] autofill_value_first,
  input wire logic [63:0] autofill_value_second,
  input wire logic error_event,
  input wire logic warning_event,
  input wire logic trigger_queue_full,
  input wire logic no_input_lock,
  output logic [263:0] lane_frame,
  output logic lane_frame_strobe,
  output logic [3:0] lane_active,
  output logic readback_overflow
);

  localparam int FRAME_CYC = (`MLOF_FRAME_BITS * 1000) /
                             (`MLOF_LANE_RATE_MBPS * `MLOF_MCLK_PERIOD_NS);
  localparam logic [3:0] FRAME_LAST = 4'(FRAME_CYC - 1);
  localparam logic [3:0] RDQ_FULL = 4'(`MLOF_RDQ_DEPTH);

  // ----------------------------------------------------------------
  // frame period: divider or external clock
  // ----------------------------------------------------------------
  logic ext_meta;
  logic ext_sync;
  logic ext_last;
  logic [3:0] base_cnt;
  logic [2:0] div_cnt;
  logic [2:0] div_mask;
  logic base_tick;
  logic tick;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_last <= 1'b0;
    end else begin
      ext_meta <= ext_clk_pin;
      ext_sync <= ext_meta;
      ext_last <= ext_sync;
    end
  end

  always_comb begin
    unique case (rate_div_sel)
      2'h0: div_mask = 3'h0;
      2'h1: div_mask = 3'h1;
      2'h2: div_mask = 3'h3;
      2'h3: div_mask = 3'h7;
    endcase
  end

  assign base_tick = (base_cnt == FRAME_LAST);
  // one frame per external rising edge when the external clock is chosen
  assign tick = ext_clk_sel ? (ext_sync & ~ext_last) :
                (base_tick && ((div_cnt & div_mask) == 3'h0));

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      base_cnt <= 4'h0;
      div_cnt <= 3'h0;
    end else if (base_tick) begin
      base_cnt <= 4'h0;
      div_cnt <= 3'(div_cnt + 3'h1);
    end else begin
      base_cnt <= 4'(base_cnt + 4'h1);
    end
  end

  // ----------------------------------------------------------------
  // active lanes
  // ----------------------------------------------------------------
  logic [3:0] lane_mask;

  always_comb begin
    unique case (active_lanes_sel)
      2'h0: lane_mask = 4'h1;
      2'h1: lane_mask = 4'h3;
      2'h2: lane_mask = 4'h7;
      2'h3: lane_mask = 4'hf;
    endcase
  end

  // ----------------------------------------------------------------
  // record pairing into per-lane data frames
  // ----------------------------------------------------------------
  logic [31:0] rec_word;
  logic [31:0] first_rec;
  logic have_first;
  logic [1:0] wr_lane;
  logic [63:0] hold [4];
  logic [3:0] hold_full;
  logic take;
  logic pair_done;
  logic all_full;
  logic send_data;

  always_comb begin
    if (rec_is_header) begin
      rec_word = {`MLOF_HDR_MARK, rec_trigger_id, rec_trigger_tag,
                  rec_bunch_crossing_count};
    end else begin
      rec_word = {rec_pixel_addr, rec_charge};
    end
  end

  // a full holding slot stalls the source until the next data slot
  assign rec_ready = ~hold_full[wr_lane];
  assign take = rec_valid & rec_ready;
  assign pair_done = take & have_first;
  assign all_full = &(hold_full | ~lane_mask);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      have_first <= 1'b0;
      first_rec <= 32'h0;
    end else if (take) begin
      have_first <= ~have_first;
      if (!have_first) begin
        first_rec <= rec_word;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_lane <= 2'h0;
    end else if (!lane_mask[wr_lane]) begin
      wr_lane <= 2'h0;
    end else if (pair_done) begin
      if (!lane_mask[2'(wr_lane + 2'h1)] || wr_lane == 2'h3) begin
        wr_lane <= 2'h0;
      end else begin
        wr_lane <= 2'(wr_lane + 2'h1);
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hold_full <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        hold[i] <= 64'h0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (send_data && lane_mask[i]) begin
          hold_full[i] <= 1'b0;
        end
        if (pair_done && wr_lane == 2'(i)) begin
          hold_full[i] <= 1'b1;
          hold[i] <= {first_rec, rec_word};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // slot sequencing
  // ----------------------------------------------------------------
  logic [7:0] slot_cnt;
  logic reg_slot;
  logic reg_tick;
  mlof_pkg::mlof_kind_t kind;

  assign reg_slot = (slot_cnt >= data_slots);
  assign reg_tick = tick & reg_slot;
  assign send_data = tick & ~reg_slot & all_full;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      slot_cnt <= 8'h0;
    end else if (tick) begin
      if (reg_slot) begin
        slot_cnt <= 8'h0;
      end else begin
        slot_cnt <= 8'(slot_cnt + 8'h1);
      end
    end
  end

  always_comb begin
    if (reg_slot) begin
      kind = mlof_pkg::MLOF_REG;
    end else if (all_full) begin
      kind = mlof_pkg::MLOF_DATA;
    end else begin
      kind = mlof_pkg::MLOF_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // status: error and warning since the last register frame, lock and trigger full current
  // ----------------------------------------------------------------
  logic err_seen;
  logic warn_seen;
  logic [3:0] status;

  // a new event in the clearing cycle survives into the next period
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      err_seen <= 1'b0;
      warn_seen <= 1'b0;
    end else begin
      err_seen <= error_event | (err_seen & ~reg_tick);
      warn_seen <= warning_event | (warn_seen & ~reg_tick);
    end
  end

  always_comb begin
    if (no_input_lock) begin
      status = `MLOF_ST_NO_LOCK;
    end else if (trigger_queue_full) begin
      status = `MLOF_ST_TRIG_FULL;
    end else if (err_seen && warn_seen) begin
      status = `MLOF_ST_BOTH;
    end else if (err_seen) begin
      status = `MLOF_ST_ERROR;
    end else if (warn_seen) begin
      status = `MLOF_ST_WARN;
    end else begin
      status = `MLOF_ST_READY;
    end
  end

  // ----------------------------------------------------------------
  // read-back queue, lane 0 only
  // ----------------------------------------------------------------
  mlof_pkg::mlof_rdq_t rdq [`MLOF_RDQ_DEPTH];
  logic [2:0] rd_ptr;
  logic [2:0] wr_ptr;
  logic [3:0] rdq_cnt;
  logic [9:0] req_eaddr;
  logic push;
  logic [1:0] pop_n;
  mlof_pkg::mlof_rdq_t head0;
  mlof_pkg::mlof_rdq_t head1;

  // the value is captured at request time since the portal moves on
  assign req_eaddr = (readback_reg_addr == 9'h0) ?
                     {1'b1, pixel_row_addr} :
                     {1'b0, readback_reg_addr};
  assign push = register_readback_request && (rdq_cnt != RDQ_FULL);
  assign head0 = rdq[rd_ptr];
  assign head1 = rdq[3'(rd_ptr + 3'h1)];

  always_comb begin
    pop_n = 2'h0;
    if (reg_tick && !readback_overflow) begin
      if (rdq_cnt >= 4'h2) begin
        pop_n = 2'h2;
      end else if (rdq_cnt == 4'h1) begin
        pop_n = 2'h1;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= 3'h0;
      for (int i = 0; i < `MLOF_RDQ_DEPTH; i++) begin
        rdq[i] <= '0;
      end
    end else if (push) begin
      rdq[wr_ptr] <= '{eaddr: req_eaddr, value: readback_value};
      wr_ptr <= 3'(wr_ptr + 3'h1);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rd_ptr <= 3'h0;
      rdq_cnt <= 4'h0;
    end else begin
      rd_ptr <= 3'(rd_ptr + {1'b0, pop_n});
      rdq_cnt <= 4'(rdq_cnt + {3'h0, push} - {2'h0, pop_n});
    end
  end

  // overflow is reported once as an error frame on lane 0
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      readback_overflow <= 1'b0;
    end else begin
      readback_overflow <= (register_readback_request && !push) |
                           (readback_overflow & ~reg_tick);
    end
  end

  // ----------------------------------------------------------------
  // per-lane payload, scrambling and output
  // ----------------------------------------------------------------
  logic [63:0] payload [4];
  logic [63:0] scr [4];
  logic [25:0] auto_a [4];
  logic [25:0] auto_b [4];
  logic [65:0] lane_word [4];

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      auto_a[i] = {autofill_select_first[i*10 +: 10],
                   autofill_value_first[i*16 +: 16]};
      auto_b[i] = {autofill_select_second[i*10 +: 10],
                   autofill_value_second[i*16 +: 16]};
      unique case (kind)
        mlof_pkg::MLOF_DATA: payload[i] = hold[i];
        mlof_pkg::MLOF_IDLE: payload[i] = {`MLOF_IDLE_CODE, 56'h0};
        mlof_pkg::MLOF_REG: payload[i] = {`MLOF_ZZ_AUTO_AUTO,
                                          auto_a[i], auto_b[i],
                                          status};
      endcase
    end
    if (kind == mlof_pkg::MLOF_REG) begin
      if (readback_overflow) begin
        payload[0] = {`MLOF_ZZ_ERROR, 52'h0, status};
      end else if (rdq_cnt >= 4'h2) begin
        payload[0] = {`MLOF_ZZ_REQ_REQ, head0, head1, status};
      end else if (rdq_cnt == 4'h1) begin
        payload[0] = {`MLOF_ZZ_AUTO_REQ, auto_a[0], head0,
                      status};
      end
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_lane
    mlof_scrambler u_scr (
      .mclk(mclk),
      .nrst(nrst),
      .advance(tick & lane_mask[g]),
      .payload(payload[g]),
      .scrambled(scr[g])
    );
    assign lane_frame[g*66 +: 66] = lane_word[g];
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lane_frame_strobe <= 1'b0;
      lane_active <= 4'h1;
      for (int i = 0; i < 4; i++) begin
        lane_word[i] <= 66'h0;
      end
    end else begin
      lane_frame_strobe <= tick;
      if (tick) begin
        lane_active <= lane_mask;
        for (int i = 0; i < 4; i++) begin
          if (!lane_mask[i]) begin
            lane_word[i] <= 66'h0;
          end else if (kind == mlof_pkg::MLOF_DATA) begin
            lane_word[i] <= {`MLOF_SYNC_DATA, scr[i]};
          end else begin
            lane_word[i] <= {`MLOF_SYNC_CTRL, scr[i]};
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

// >>> dv/mlof_daq_rx.sv
// receiver model: descrambles every lane of each transmitted frame
// assumes lane_frame and its strobe come from the framer on mclk
`timescale 1ns/1ps
`default_nettype none

module mlof_daq_rx (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [263:0] lane_frame,
  input wire logic lane_frame_strobe,
  output logic [255:0] rx_pl,
  output logic [7:0] rx_sync,
  output logic rx_hdr,
  output logic rx_valid
);
  logic [57:0] st [4];

  // -------------------------------------------------------
  // descrambler, self-synchronising after one frame
  // -------------------------------------------------------
  always @(posedge mclk or negedge nrst) begin : rx_p
    logic [57:0] s;
    logic [63:0] d;
    if (!nrst) begin
      rx_valid <= 1'b0;
      rx_pl <= '0;
      rx_sync <= '0;
      rx_hdr <= 1'b0;
      for (int i = 0; i < 4; i++) st[i] <= '1;
    end else begin
      rx_valid <= lane_frame_strobe;
      if (lane_frame_strobe) begin
        for (int i = 0; i < 4; i++) begin
          s = st[i];
          for (int k = 0; k < 64; k++) begin
            d[k] = lane_frame[i*66+k] ^ s[38] ^ s[57];
            s = {s[56:0], lane_frame[i*66+k]};
          end
          st[i] <= s;
          rx_pl[i*64+:64] <= d;
          rx_sync[i*2+:2] <= lane_frame[i*66+64+:2];
          // any other leading pattern counts as hit data
          if (i == 0) rx_hdr <= d[63:57] == 7'h01;
        end
      end
    end
  end
endmodule

`default_nettype wire

// >>> dv/mlof_chk.sv
// checker of frame timing, lane alignment and overflow flag
// assumes binding into mlof_output_framer; sees only its ports
`timescale 1ns/1ps
`default_nettype none

module mlof_chk (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ext_clk_sel,
  input wire logic ext_clk_pin,
  input wire logic [7:0] data_slots,
  input wire logic register_readback_request,
  input wire logic [263:0] lane_frame,
  input wire logic lane_frame_strobe,
  input wire logic [3:0] lane_active,
  input wire logic readback_overflow
);
  logic [3:0] same;
  logic [3:0] zero;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      same[i] = !lane_active[i] ||
        lane_frame[i*66+64+:2] == lane_frame[65:64];
      zero[i] = lane_active[i] || lane_frame[i*66+:66] == 66'h0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // -------------------------------------------------------
  // properties
  // -------------------------------------------------------
  sequence ext_edge;
    ext_clk_sel && $rose(ext_clk_pin);
  endsequence
  sequence quiet_gap;
    !lane_frame_strobe [*4];
  endsequence

  sync_legal_a: assert property (lane_frame_strobe |->
    lane_frame[65:64] inside {2'h1, 2'h2}) else $error("bad sync");
  lanes_aligned_a: assert property (lane_frame_strobe |-> &same)
    else $error("lanes differ in sync");
  idle_lanes_a: assert property (lane_frame_strobe |-> &zero)
    else $error("inactive lane not zero");
  lane_mask_a: assert property (lane_active inside
    {4'h1, 4'h3, 4'h7, 4'hf}) else $error("lane mask broken");
  frame_gap_a: assert property (lane_frame_strobe |=> quiet_gap)
    else $error("frames too close");
  ext_tick_a: assert property (ext_edge |-> ##[2:6] lane_frame_strobe)
    else $error("no frame after external edge");
  reg_only_a: assert property (lane_frame_strobe && data_slots == 8'h00
    |-> lane_frame[65:64] == 2'h2) else $error("data with zero slots");
  ovf_cause_a: assert property ($rose(readback_overflow)
    |-> $past(register_readback_request)) else $error("overflow alone");
  ovf_clear_a: assert property ($fell(readback_overflow)
    |-> lane_frame_strobe || $past(lane_frame_strobe))
    else $error("overflow cleared off frame");
endmodule

bind mlof_output_framer mlof_chk chk (.mclk(mclk), .nrst(nrst),
  .ext_clk_sel(ext_clk_sel), .ext_clk_pin(ext_clk_pin),
  .data_slots(data_slots), .lane_frame(lane_frame),
  .register_readback_request(register_readback_request),
  .lane_frame_strobe(lane_frame_strobe), .lane_active(lane_active),
  .readback_overflow(readback_overflow));

`default_nettype wire

// >>> dv/multilane_output_framer_tb.sv
// self-checking bench of the framer with a descrambling receiver
// assumes mlof_consts.svh on the include path
`timescale 1ns/1ps
`default_nettype none
`include "mlof_consts.svh"

module multilane_output_framer_tb;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] active_lanes_sel = 2'h0;
  logic [1:0] rate_div_sel = 2'h3;
  logic ext_clk_sel = 1'b0;
  logic ext_clk_pin = 1'b0;
  logic [7:0] data_slots = 8'h00;
  logic rec_valid = 1'b0;
  logic rec_is_header = 1'b0;
  logic [15:0] rec_pixel_addr = 16'h0, rec_charge = 16'h0;
  logic [4:0] rec_trigger_id = 5'h0, rec_trigger_tag = 5'h0;
  logic [14:0] rec_bunch_crossing_count = 15'h0;
  logic register_readback_request = 1'b0;
  logic [8:0] readback_reg_addr = 9'h0, pixel_row_addr = 9'h0, a1;
  logic [15:0] readback_value = 16'h0, seed, v1, v2;
  logic [39:0] autofill_select_first, autofill_select_second;
  logic [63:0] autofill_value_first, autofill_value_second;
  logic error_event = 1'b0, warning_event = 1'b0;
  logic trigger_queue_full = 1'b0, no_input_lock = 1'b0;
  logic rec_ready, lane_frame_strobe, readback_overflow, rx_hdr, rx_valid;
  logic [263:0] lane_frame;
  logic [3:0] lane_active;
  logic [255:0] rx_pl;
  logic [7:0] rx_sync;
  logic [31:0] rec [8];
  logic [3:0] stab [5] = '{4'h3, 4'h2, 4'h1, 4'h4, 4'h8};
  logic ext_run = 1'b0;
  int err_count = 0, total_checks = 0, cyc = 0, ext_cnt = 0, n;

  mlof_output_framer uut (.mclk, .nrst, .active_lanes_sel, .rate_div_sel,
    .ext_clk_sel, .ext_clk_pin, .data_slots, .rec_valid, .rec_ready,
    .rec_is_header, .rec_pixel_addr, .rec_charge, .rec_trigger_id,
    .rec_trigger_tag, .rec_bunch_crossing_count,
    .register_readback_request, .readback_reg_addr, .readback_value,
    .pixel_row_addr, .autofill_select_first, .autofill_select_second,
    .autofill_value_first, .autofill_value_second, .error_event,
    .warning_event, .trigger_queue_full, .no_input_lock, .lane_frame,
    .lane_frame_strobe, .lane_active, .readback_overflow);
  mlof_daq_rx rx (.mclk, .nrst, .lane_frame, .lane_frame_strobe, .rx_pl,
    .rx_sync, .rx_hdr, .rx_valid);

  // -------------------------------------------------------
  // clock, external pin, timeout
  // -------------------------------------------------------
  initial forever #5 mclk = ~mclk;
  always @(negedge mclk) begin
    if (ext_run) begin
      ext_cnt <= (ext_cnt == 19) ? 0 : ext_cnt + 1;
      if (ext_cnt == 19) ext_clk_pin <= !ext_clk_pin;
    end
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end

  // -------------------------------------------------------
  // helpers
  // -------------------------------------------------------
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  function automatic logic [25:0] afa(input int i);
    return {autofill_select_first[i*10+:10], autofill_value_first[i*16+:16]};
  endfunction
  function automatic logic [25:0] afb(input int i);
    return {autofill_select_second[i*10+:10],
      autofill_value_second[i*16+:16]};
  endfunction
  function automatic logic [63:0] auto_pl(input int i);
    return {`MLOF_ZZ_AUTO_AUTO, afa(i), afb(i), 4'h0};
  endfunction
  function automatic logic [3:0] st_exp(input logic [3:0] e);
    // priority: lock lost, trigger full, both, error, warning
    if (e[3]) return `MLOF_ST_NO_LOCK;
    if (e[2]) return `MLOF_ST_TRIG_FULL;
    if (e[1] && e[0]) return `MLOF_ST_BOTH;
    if (e[1]) return `MLOF_ST_ERROR;
    return e[0] ? `MLOF_ST_WARN : `MLOF_ST_READY;
  endfunction
  task automatic chk(input string nm, input logic [63:0] e,
      input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic frame();
    @(negedge mclk);
    while (rx_valid !== 1'b1) @(negedge mclk);
  endtask
  task automatic gap(output int c);
    c = 0;
    do begin
      @(negedge mclk);
      c++;
    end while (rx_valid !== 1'b1);
  endtask
  task automatic get_reg(output int c);
    c = 0;
    do begin
      frame();
      c++;
    end while (!(rx_sync[1:0] === 2'h2 && rx_pl[63:56] !== `MLOF_IDLE_CODE)
      && c < 12);
  endtask
  // request stays high; the caller lowers it after the last one
  task automatic rd(input logic [8:0] a, input logic [15:0] v);
    register_readback_request = 1'b1;
    readback_reg_addr = a;
    readback_value = v;
    @(negedge mclk);
  endtask
  task automatic send(input logic h, input logic [31:0] r);
    rec_valid = 1'b1;
    rec_is_header = h;
    {rec_pixel_addr, rec_charge} = r;
    {rec_trigger_id, rec_trigger_tag, rec_bunch_crossing_count} = r[24:0];
    while (rec_ready !== 1'b1) @(negedge mclk);
    @(negedge mclk);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // -------------------------------------------------------
  // main sequence
  // -------------------------------------------------------
  initial begin
    seed = 16'hb2c5;
    autofill_select_first = 40'({rnd(), rnd(), rnd()});
    autofill_select_second = 40'({rnd(), rnd(), rnd()});
    autofill_value_first = {rnd(), rnd(), rnd(), rnd()};
    autofill_value_second = {rnd(), rnd(), rnd(), rnd()};
    repeat (2) @(negedge mclk);
    chk("reset lanes", 64'h1, 64'(lane_active));
    chk("reset ovf", 64'h0, 64'(readback_overflow));
    nrst = 1'b1;
    repeat (3) frame();
    chk("auto only", auto_pl(0), rx_pl[63:0]);
    for (int k = 0; k < 5; k++) begin
      {no_input_lock, trigger_queue_full, error_event, warning_event} =
        stab[k];
      @(negedge mclk);
      error_event = 1'b0;
      warning_event = 1'b0;
      frame();
      chk("status", 64'(st_exp(stab[k])), 64'(rx_pl[3:0]));
      no_input_lock = 1'b0;
      trigger_queue_full = 1'b0;
    end
    frame();
    a1 = 9'(rnd()) | 9'h1;
    v1 = rnd();
    v2 = rnd();
    pixel_row_addr = 9'(rnd());
    rd(a1, v1);
    register_readback_request = 1'b0;
    frame();
    chk("one req", {`MLOF_ZZ_AUTO_REQ, afa(0), 1'b0, a1, v1, 4'h0},
      rx_pl[63:0]);
    frame();
    rd(a1, v1);
    rd(9'h0, v2);
    register_readback_request = 1'b0;
    frame();
    chk("two req", {`MLOF_ZZ_REQ_REQ, 1'b0, a1, v1, 1'b1,
      pixel_row_addr, v2, 4'h0}, rx_pl[63:0]);
    active_lanes_sel = 2'h3;
    data_slots = 8'h02;
    repeat (3) frame();
    for (int i = 0; i < 8; i++) rec[i] = {rnd(), rnd()};
    rec[0][31:25] = `MLOF_HDR_MARK;
    for (int i = 0; i < 8; i++) send(i == 0, rec[i]);
    rec_valid = 1'b0;
    n = 0;
    do begin
      frame();
      n++;
    end while (rx_sync[1:0] !== 2'h1 && n < 8);
    chk("hdr flag", 64'h1, 64'(rx_hdr));
    for (int i = 0; i < 4; i++) begin
      chk("data sync", 64'h1, 64'(rx_sync[i*2+:2]));
      chk("data lane", {rec[2*i], rec[2*i+1]}, rx_pl[i*64+:64]);
    end
    get_reg(n);
    get_reg(n);
    chk("slot gap", 64'(data_slots) + 64'h1, 64'(n));
    for (int i = 0; i < 4; i++)
      chk("auto lane", auto_pl(i), rx_pl[i*64+:64]);
    frame();
    rd(a1, v1);
    register_readback_request = 1'b0;
    get_reg(n);
    chk("lane0 req", {`MLOF_ZZ_AUTO_REQ, afa(0), 1'b0, a1, v1, 4'h0},
      rx_pl[63:0]);
    for (int i = 1; i < 4; i++)
      chk("lane auto", auto_pl(i), rx_pl[i*64+:64]);
    for (int s = 0; s < 4; s++) begin
      rate_div_sel = 2'(s);
      repeat (2) frame();
      gap(n);
      chk("rate gap", 64'(5 << s), 64'(n));
    end
    ext_clk_sel = 1'b1;
    ext_run = 1'b1;
    repeat (3) frame();
    gap(n);
    chk("ext gap", 64'd40, 64'(n));
    ext_run = 1'b0;
    // internal ticks are not aligned to the last external frame
    repeat (5) @(negedge mclk);
    ext_clk_sel = 1'b0;
    rate_div_sel = 2'h3;
    repeat (2) frame();
    repeat (9) rd(a1, v1);
    register_readback_request = 1'b0;
    chk("ovf flag", 64'h1, 64'(readback_overflow));
    get_reg(n);
    chk("err code", 64'(`MLOF_ZZ_ERROR), 64'(rx_pl[63:56]));
    chk("ovf clear", 64'h0, 64'(readback_overflow));
    final_report();
  end
endmodule

`default_nettype wire
